/* File: bench/lgc_host_model.sv */
// Host processor model driving the synchronous register port.
// Assumes one clock shared with the register bank.
`timescale 1ns/1ps
`default_nettype none
module lgc_host_model
(
	input  wire logic             clk_in,
	input  wire logic [7:0]       rdata_in,
	output var lgc_pkg::lgc_host_req_t req_out
);
	initial req_out = '0;
	// Released bus shows inverted lines so stale values never match
	task automatic write(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
	endtask
	task automatic read(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk_in);
		req_out <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		#1;
		d = rdata_in;
	endtask
	task automatic hold_reset(input logic [7:0] g);
		write(8'h80, g | 8'h01);
		repeat (lgc_pkg::SOFT_RST_MIN_CYC + 1) @(posedge clk_in);
	endtask
endmodule
`default_nettype wire

/* File: bench/lgc_regs_monitor.sv */
// Checker for the register bank: host port, segment and control outputs.
// Assumes it is bound to lgc_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module lgc_regs_monitor
#(
	parameter int NUM_CH = 8
)
(
	input wire logic                   clk_in,
	input wire logic                   srst_in,
	input wire lgc_pkg::lgc_host_req_t host_req_in,
	input wire logic [7:0]             rdata_out,
	input wire logic                   irq_out,
	input wire lgc_pkg::lgc_gctrl_t    gctrl_out,
	input wire logic [NUM_CH*21-1:0]   seg_out,
	input wire logic [NUM_CH*3-1:0]    seg_positive_out,
	input wire logic [NUM_CH-1:0]      tpos_out,
	input wire logic [NUM_CH-1:0]      tneg_out,
	input wire logic [NUM_CH-1:0]      rx_data_out
);
	default clocking @(posedge clk_in);
	endclocking
	default disable iff (srst_in);
	property p_seg6;
		host_req_in.wr && host_req_in.addr == 8'h0d |=> seg_out[6:0] == $past(host_req_in.wdata[6:0]);
	endproperty
	a_seg6: assert property (p_seg6) else $error("seg six write lost");
	property p_seg7;
		host_req_in.wr && host_req_in.addr == 8'h0e |=> seg_out[13:7] == $past(host_req_in.wdata[6:0]);
	endproperty
	a_seg7: assert property (p_seg7) else $error("seg seven write lost");
	property p_seg8;
		host_req_in.wr && host_req_in.addr == 8'h0f |=> seg_out[20:14] == $past(host_req_in.wdata[6:0]);
	endproperty
	a_seg8: assert property (p_seg8) else $error("seg eight write lost");
	property p_sign;
		seg_positive_out[2:0] == {seg_out[20], seg_out[13], seg_out[6]};
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag wrong");
	property p_gctrl;
		host_req_in.wr && host_req_in.addr == 8'h80
		|=> gctrl_out == {$past(host_req_in.wdata[7:3]), $past(host_req_in.wdata[1:0])};
	endproperty
	a_gctrl: assert property (p_gctrl) else $error("control write lost");
	property p_irq_gate;
		!gctrl_out.global_interrupt_enable |=> !irq_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("interrupt while disabled");
	property p_rdseg;
		host_req_in.rd && host_req_in.addr == 8'h0d |=> rdata_out == {1'b0, $past(seg_out[6:0])};
	endproperty
	a_rdseg: assert property (p_rdseg) else $error("seg read wrong");
	property p_unmapped;
		host_req_in.rd && host_req_in.addr == 8'h81 |=> rdata_out == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_software_reset_bit;
		gctrl_out.software_reset_bit |=> (tpos_out | tneg_out | rx_data_out) == '0;
	endproperty
	a_software_reset_bit: assert property (p_software_reset_bit) else $error("path active in soft reset");
	property p_keep;
		gctrl_out.software_reset_bit && !host_req_in.wr |=> $stable(seg_out);
	endproperty
	a_keep: assert property (p_keep) else $error("segments lost in soft reset");
	c_wr: cover property (host_req_in.wr && host_req_in.addr == 8'h80);
	c_irq: cover property ($rose(irq_out));
	c_srst: cover property (gctrl_out.software_reset_bit);
endmodule
bind lgc_regs lgc_regs_monitor #(.NUM_CH(NUM_CH)) i_lgc_regs_monitor (.clk_in(clk_in),
	.srst_in(srst_in), .host_req_in(host_req_in), .rdata_out(rdata_out), .irq_out(irq_out),
	.gctrl_out(gctrl_out), .seg_out(seg_out), .seg_positive_out(seg_positive_out),
	.tpos_out(tpos_out), .tneg_out(tneg_out), .rx_data_out(rx_data_out));
`default_nettype wire

/* File: bench/tb.sv */
// Self-checking bench for the register bank and its channel paths.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] tclk = '0, tpos = '0, tneg = '0, rclk = '0, rdat = '0, los = '0;
	lgc_pkg::lgc_host_req_t req;
	logic [7:0] rdata_out, tpos_out, tneg_out, rx_data_out, g, d;
	logic irq_out;
	lgc_pkg::lgc_gctrl_t gctrl_out;
	logic [167:0] seg_out;
	logic [23:0] seg_positive_out;
	logic [1:0] s, r;
	int n_errors = 0;
	int check_count = 0;
	always #20 clk_in = ~clk_in;
	lgc_regs i_lgc_regs (.clk_in(clk_in), .srst_in(srst_in), .host_req_in(req), .tclk_in(tclk),
		.tpos_in(tpos), .tneg_in(tneg), .rclk_in(rclk), .rdata_in(rdat), .los_in(los),
		.rdata_out(rdata_out), .irq_out(irq_out), .gctrl_out(gctrl_out), .seg_out(seg_out),
		.seg_positive_out(seg_positive_out), .tpos_out(tpos_out), .tneg_out(tneg_out),
		.rx_data_out(rx_data_out));
	lgc_host_model i_lgc_host_model (.clk_in(clk_in), .rdata_in(rdata_out), .req_out(req));
	task automatic summarize();
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
		check_count++;
		if (v !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, v);
		end
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		i_lgc_host_model.read(a, v);
		chk("rdata", e, v);
	endtask
	// Data changes between the two clock edges, so the sampling edge shows
	task automatic line(input logic [1:0] a, input logic [1:0] b);
		@(posedge clk_in);
		{tneg, tpos, rdat} <= {{8{a[1]}}, {8{a[0]}}, {8{a[0]}}};
		repeat (2) @(posedge clk_in);
		{tclk, rclk} <= 16'hffff;
		repeat (3) @(posedge clk_in);
		{tneg, tpos, rdat} <= {{8{b[1]}}, {8{b[0]}}, {8{b[0]}}};
		repeat (2) @(posedge clk_in);
		{tclk, rclk} <= 16'h0000;
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	function automatic logic [7:0] segval(input int ch, input int k);
		return 8'(ch * 37 + k * 83) ^ 8'h80;
	endfunction
	initial
	begin
		repeat (10) @(posedge clk_in);
		srst_in <= 1'b0;
		rd_chk(8'h80, 8'h00);
		i_lgc_host_model.write(8'h80, 8'hff);
		#1;
		chk("gctrl", 8'h7f, {1'b0, gctrl_out});
		rd_chk(8'h80, 8'hfb);
		i_lgc_host_model.write(8'h81, 8'hff);
		rd_chk(8'h81, 8'h00);
		for (int ch = 0; ch < 8; ch++)
			for (int k = 0; k < 3; k++)
				i_lgc_host_model.write(8'(ch * 16 + 13 + k), segval(ch, k));
		for (int ch = 0; ch < 8; ch++)
			for (int k = 0; k < 3; k++)
			begin
				d = segval(ch, k);
				rd_chk(8'(ch * 16 + 13 + k), d & 8'h7f);
				chk("sign", {7'h00, d[6]}, {7'h00, seg_positive_out[ch * 3 + k]});
			end
		for (int m = 0; m < 16; m++)
		begin
			g = {m[3], 1'b0, m[2], m[1], m[0], 3'b000};
			i_lgc_host_model.write(8'h80, g);
			line(2'b01, 2'b10);
			s = m[1] ? 2'b01 : 2'b10;
			r = m[2] ? 2'b10 : 2'b01;
			chk("tpos", {8{s[0] ^ m[0]}}, tpos_out);
			chk("tneg", m[3] ? 8'h00 : {8{s[1] ^ m[0]}}, tneg_out);
			chk("rx", {8{r[0] ^ m[0]}}, rx_data_out);
		end
		i_lgc_host_model.write(8'h04, 8'h02);
		i_lgc_host_model.write(8'h80, 8'h00);
		los <= 8'hff;
		repeat (6) @(posedge clk_in);
		#1;
		chk("irq", 8'h00, {7'h00, irq_out});
		rd_chk(8'h06, 8'h02);
		rd_chk(8'h06, 8'h00);
		i_lgc_host_model.write(8'h80, 8'h02);
		los <= 8'h00;
		for (int i = 0; i < 8 && irq_out !== 1'b1; i++)
			@(posedge clk_in);
		chk("irq", 8'h01, {7'h00, irq_out});
		if (irq_out !== 1'b1)
			summarize();
		rd_chk(8'h06, 8'h02);
		repeat (3) @(posedge clk_in);
		#1;
		chk("irq", 8'h00, {7'h00, irq_out});
		@(posedge clk_in);
		los <= 8'hff;
		i_lgc_host_model.write(8'h80, 8'hc0);
		line(2'b00, 2'b00);
		chk("ones", 8'hff, tpos_out);
		i_lgc_host_model.write(8'h80, 8'h80);
		line(2'b00, 2'b00);
		chk("ones", 8'h00, tpos_out);
		// Dual rail: every bit is a mark on one rail, rails alternate
		i_lgc_host_model.write(8'h80, 8'h40);
		line(2'b00, 2'b00);
		chk("marks", 8'hff, tpos_out ^ tneg_out);
		g = tpos_out;
		line(2'b00, 2'b00);
		chk("marks", ~g, tpos_out);
		@(posedge clk_in);
		los <= 8'h00;
		i_lgc_host_model.hold_reset(8'h00);
		line(2'b11, 2'b11);
		chk("tpos", 8'h00, tpos_out | tneg_out | rx_data_out);
		rd_chk(8'h0d, segval(0, 0) & 8'h7f);
		i_lgc_host_model.write(8'h80, 8'h00);
		line(2'b11, 2'b11);
		chk("tpos", 8'hff, tpos_out & tneg_out & rx_data_out);
		summarize();
	end
endmodule
`default_nettype wire

/* File: hw/lgc_chan_path.sv */
// One channel data path steered by the global control bits.
// Assumes line clocks and data arrive synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module lgc_chan_path
(
	input  wire logic              clk_in,
	input  wire logic              srst_in,
	input  wire lgc_pkg::lgc_gctrl_t cfg_in,
	input  wire logic              tclk_in,
	input  wire logic              tpos_in,
	input  wire logic              tneg_in,
	input  wire logic              rclk_in,
	input  wire logic              rdata_in,
	input  wire logic              los_in,
	output logic                   tpos_out,
	output logic                   tneg_out,
	output logic                   rdata_out,
	output logic                   los_chg_out
);
	logic tclk_ff, rclk_ff, los_ff, mark_ff;
	logic tpos_ff, tneg_ff, rdata_ff, chg_ff;
	logic nxt_tclk, nxt_rclk, nxt_los, nxt_mark;
	logic nxt_tpos, nxt_tneg, nxt_rdata, nxt_chg;
	logic t_edge, r_edge, pos_in, neg_in;

	always_comb
	begin
		// Edge choice for both directions
		t_edge = cfg_in.transmit_sample_edge ? (tclk_in & ~tclk_ff)
			: (~tclk_in & tclk_ff);
		r_edge = cfg_in.receive_update_edge ? (~rclk_in & rclk_ff)
			: (rclk_in & ~rclk_ff);
		pos_in = tpos_in ^ cfg_in.data_polarity_select;
		neg_in = tneg_in ^ cfg_in.data_polarity_select;
		nxt_tclk  = tclk_in;
		nxt_rclk  = rclk_in;
		nxt_los   = los_in;
		nxt_chg   = los_in ^ los_ff;
		nxt_mark  = mark_ff;
		nxt_tpos  = tpos_ff;
		nxt_tneg  = tneg_ff;
		nxt_rdata = rdata_ff;
		if (t_edge)
		begin
			if (cfg_in.auto_all_ones_on_los && los_in)
			begin
				// All ones; dual rail alternates marks as a line would
				nxt_mark = ~mark_ff;
				nxt_tpos = cfg_in.rail_format_select | ~mark_ff;
				nxt_tneg = ~cfg_in.rail_format_select & mark_ff;
			end
			else
			begin
				nxt_tpos = pos_in;
				// Single rail: negative input is a code select, not data
				nxt_tneg = cfg_in.rail_format_select ? 1'b0 : neg_in;
			end
		end
		if (r_edge)
			nxt_rdata = rdata_in ^ cfg_in.data_polarity_select;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			tclk_ff  <= 1'b0;
			rclk_ff  <= 1'b0;
			los_ff   <= 1'b0;
			chg_ff   <= 1'b0;
			mark_ff  <= 1'b0;
			tpos_ff  <= 1'b0;
			tneg_ff  <= 1'b0;
			rdata_ff <= 1'b0;
		end
		else
		begin
			tclk_ff  <= nxt_tclk;
			rclk_ff  <= nxt_rclk;
			los_ff   <= nxt_los;
			chg_ff   <= nxt_chg;
			mark_ff  <= nxt_mark;
			tpos_ff  <= nxt_tpos;
			tneg_ff  <= nxt_tneg;
			rdata_ff <= nxt_rdata;
		end
	end

	assign tpos_out    = tpos_ff;
	assign tneg_out    = tneg_ff;
	assign rdata_out   = rdata_ff;
	assign los_chg_out = chg_ff;
endmodule
`default_nettype wire

/* File: hw/lgc_pkg.sv */
// Package for the global control and pulse segment register bank.
// Assumes one 25 MHz clock and the host port of the top module.
`default_nettype none
package lgc_pkg;

	// ----------------------------------------------------------------
	// Sizes
	// ----------------------------------------------------------------
	localparam int NUM_CH = 8;
	localparam int AW     = 8;
	localparam int DW     = 8;
	localparam int SEG_W  = 7;

	// ----------------------------------------------------------------
	// Register offsets within a channel stride of 0x10
	// ----------------------------------------------------------------
	localparam logic [3:0] OFS_INT_EN = 4'h4;
	localparam logic [3:0] OFS_STATUS = 4'h6;
	localparam logic [3:0] OFS_SEG6   = 4'hd;
	localparam logic [3:0] OFS_SEG7   = 4'he;
	localparam logic [3:0] OFS_SEG8   = 4'hf;
	localparam logic [7:0] ADDR_GCTRL = 8'h80;

	// ----------------------------------------------------------------
	// Field positions and values after reset
	// ----------------------------------------------------------------
	localparam int BIT_RAIL      = 7;
	localparam int BIT_AUTO_ONES = 6;
	localparam int BIT_RX_EDGE   = 5;
	localparam int BIT_TX_EDGE   = 4;
	localparam int BIT_POLARITY  = 3;
	localparam int BIT_IRQ_EN    = 1;
	localparam int BIT_SOFT_RST  = 0;
	localparam int BIT_LOS_CHG   = 1;
	localparam int BIT_SIGN      = 6;

	localparam logic [7:0] GCTRL_RESET = 8'h00;
	localparam logic [7:0] GCTRL_MASK  = 8'hfb;
	localparam logic [6:0] SEG_RESET   = 7'h00;
	localparam logic [7:0] STAT_MASK   = 8'h02;

	// ----------------------------------------------------------------
	// Software reset hold time kept by the host
	// ----------------------------------------------------------------
	localparam int CLK_NS           = 40;
	localparam int SOFT_RST_MIN_NS  = 10000;
	localparam int SOFT_RST_MIN_CYC = (SOFT_RST_MIN_NS + CLK_NS - 1) / CLK_NS;

	typedef struct packed {
		logic rail_format_select;
		logic auto_all_ones_on_los;
		logic receive_update_edge;
		logic transmit_sample_edge;
		logic data_polarity_select;
		logic global_interrupt_enable;
		logic software_reset_bit;
	} lgc_gctrl_t;

	typedef struct packed {
		logic          wr;
		logic          rd;
		logic [AW-1:0] addr;
		logic [DW-1:0] wdata;
	} lgc_host_req_t;

endpackage
`default_nettype wire

/* File: hw/lgc_regs.sv */
// Global control and pulse segment register bank for eight channels.
// Assumes a synchronous host port: one-cycle wr or rd strobes, rdata a cycle later.
`timescale 1ns/1ps
`default_nettype none
module lgc_regs
#(
	parameter int NUM_CH = lgc_pkg::NUM_CH
)
(
	input  wire logic                   clk_in,
	input  wire logic                   srst_in,
	input  wire lgc_pkg::lgc_host_req_t host_req_in,
	input  wire logic [NUM_CH-1:0]      tclk_in,
	input  wire logic [NUM_CH-1:0]      tpos_in,
	input  wire logic [NUM_CH-1:0]      tneg_in,
	input  wire logic [NUM_CH-1:0]      rclk_in,
	input  wire logic [NUM_CH-1:0]      rdata_in,
	input  wire logic [NUM_CH-1:0]      los_in,
	output logic [lgc_pkg::DW-1:0]      rdata_out,
	output logic                        irq_out,
	output var lgc_pkg::lgc_gctrl_t     gctrl_out,
	output logic [NUM_CH*21-1:0]        seg_out,
	output logic [NUM_CH*3-1:0]         seg_positive_out,
	output logic [NUM_CH-1:0]           tpos_out,
	output logic [NUM_CH-1:0]           tneg_out,
	output logic [NUM_CH-1:0]           rx_data_out
);
	// ----------------------------------------------------------------
	// Elaboration check
	// ----------------------------------------------------------------
	if (NUM_CH < 1 || NUM_CH > 8)
	begin : g_bad_ch
		$error("NUM_CH must be 1 to 8");
	end

	// ----------------------------------------------------------------
	// Register state
	// ----------------------------------------------------------------
	logic [6:0] seg6_ff [NUM_CH];
	logic [6:0] seg7_ff [NUM_CH];
	logic [6:0] seg8_ff [NUM_CH];
	logic [6:0] nxt_seg6 [NUM_CH];
	logic [6:0] nxt_seg7 [NUM_CH];
	logic [6:0] nxt_seg8 [NUM_CH];
	logic [NUM_CH-1:0] int_en_ff, nxt_int_en;
	logic [NUM_CH-1:0] stat_ff, nxt_stat;
	logic [7:0]        gctrl_ff, nxt_gctrl;
	logic [7:0]        rdata_ff, nxt_rdata;
	logic              irq_ff, nxt_irq;
	logic [NUM_CH-1:0] los_chg;
	logic              core_rst;
	logic              chan_hit;
	logic [2:0]        ch;
	logic [3:0]        ofs;
	lgc_pkg::lgc_gctrl_t cfg;

	assign ch       = host_req_in.addr[6:4];
	assign ofs      = host_req_in.addr[3:0];
	assign chan_hit = ~host_req_in.addr[7] && (int'(ch) < NUM_CH);

	always_comb
	begin
		cfg.rail_format_select      = gctrl_ff[lgc_pkg::BIT_RAIL];
		cfg.auto_all_ones_on_los    = gctrl_ff[lgc_pkg::BIT_AUTO_ONES];
		cfg.receive_update_edge     = gctrl_ff[lgc_pkg::BIT_RX_EDGE];
		cfg.transmit_sample_edge    = gctrl_ff[lgc_pkg::BIT_TX_EDGE];
		cfg.data_polarity_select    = gctrl_ff[lgc_pkg::BIT_POLARITY];
		cfg.global_interrupt_enable = gctrl_ff[lgc_pkg::BIT_IRQ_EN];
		cfg.software_reset_bit      = gctrl_ff[lgc_pkg::BIT_SOFT_RST];
	end

	// Internal circuits only; the register bank itself is spared
	assign core_rst = srst_in | cfg.software_reset_bit;

	// ----------------------------------------------------------------
	// Register writes, reads and status
	// ----------------------------------------------------------------
	always_comb
	begin
		nxt_gctrl  = gctrl_ff;
		nxt_int_en = int_en_ff;
		nxt_rdata  = 8'h00;
		for (int i = 0; i < NUM_CH; i++)
		begin
			nxt_seg6[i] = seg6_ff[i];
			nxt_seg7[i] = seg7_ff[i];
			nxt_seg8[i] = seg8_ff[i];
		end
		// Read clears first so that a same-cycle change still lands
		nxt_stat = stat_ff;
		if (host_req_in.rd && chan_hit && ofs == lgc_pkg::OFS_STATUS)
			nxt_stat[ch] = 1'b0;
		nxt_stat = nxt_stat | los_chg;
		if (host_req_in.wr)
		begin
			if (host_req_in.addr == lgc_pkg::ADDR_GCTRL)
				nxt_gctrl = host_req_in.wdata & lgc_pkg::GCTRL_MASK;
			else if (chan_hit)
			begin
				case (ofs)
					lgc_pkg::OFS_INT_EN:
						nxt_int_en[ch] = host_req_in.wdata[lgc_pkg::BIT_LOS_CHG];
					lgc_pkg::OFS_SEG6:
						nxt_seg6[ch] = host_req_in.wdata[6:0];
					lgc_pkg::OFS_SEG7:
						nxt_seg7[ch] = host_req_in.wdata[6:0];
					lgc_pkg::OFS_SEG8:
						nxt_seg8[ch] = host_req_in.wdata[6:0];
					default:
						nxt_int_en = int_en_ff;
				endcase
			end
		end
		if (host_req_in.rd)
		begin
			if (host_req_in.addr == lgc_pkg::ADDR_GCTRL)
				nxt_rdata = gctrl_ff & lgc_pkg::GCTRL_MASK;
			else if (chan_hit)
			begin
				case (ofs)
					lgc_pkg::OFS_INT_EN:
						nxt_rdata = {6'h00, int_en_ff[ch], 1'b0};
					lgc_pkg::OFS_STATUS:
						nxt_rdata = {6'h00, stat_ff[ch], 1'b0} & lgc_pkg::STAT_MASK;
					lgc_pkg::OFS_SEG6:
						nxt_rdata = {1'b0, seg6_ff[ch]};
					lgc_pkg::OFS_SEG7:
						nxt_rdata = {1'b0, seg7_ff[ch]};
					lgc_pkg::OFS_SEG8:
						nxt_rdata = {1'b0, seg8_ff[ch]};
					default:
						nxt_rdata = 8'h00;
				endcase
			end
		end
		// Gated by the global enable regardless of channel enables
		nxt_irq = cfg.global_interrupt_enable && |(stat_ff & int_en_ff);
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			gctrl_ff  <= lgc_pkg::GCTRL_RESET;
			int_en_ff <= '0;
			stat_ff   <= '0;
			rdata_ff  <= 8'h00;
			irq_ff    <= 1'b0;
			for (int i = 0; i < NUM_CH; i++)
			begin
				seg6_ff[i] <= lgc_pkg::SEG_RESET;
				seg7_ff[i] <= lgc_pkg::SEG_RESET;
				seg8_ff[i] <= lgc_pkg::SEG_RESET;
			end
		end
		else
		begin
			gctrl_ff  <= nxt_gctrl;
			int_en_ff <= nxt_int_en;
			stat_ff   <= nxt_stat;
			rdata_ff  <= nxt_rdata;
			irq_ff    <= nxt_irq;
			for (int i = 0; i < NUM_CH; i++)
			begin
				seg6_ff[i] <= nxt_seg6[i];
				seg7_ff[i] <= nxt_seg7[i];
				seg8_ff[i] <= nxt_seg8[i];
			end
		end
	end

	// ----------------------------------------------------------------
	// Per channel data paths and segment outputs
	// ----------------------------------------------------------------
	for (genvar g = 0; g < NUM_CH; g++)
	begin : g_ch
		lgc_chan_path u_path
		(
			.clk_in      (clk_in),
			.srst_in     (core_rst),
			.cfg_in      (cfg),
			.tclk_in     (tclk_in[g]),
			.tpos_in     (tpos_in[g]),
			.tneg_in     (tneg_in[g]),
			.rclk_in     (rclk_in[g]),
			.rdata_in    (rdata_in[g]),
			.los_in      (los_in[g]),
			.tpos_out    (tpos_out[g]),
			.tneg_out    (tneg_out[g]),
			.rdata_out   (rx_data_out[g]),
			.los_chg_out (los_chg[g])
		);
		assign seg_out[g*21 +: 21] = {seg8_ff[g], seg7_ff[g], seg6_ff[g]};
		// Sign of each segment drives the pulse direction
		assign seg_positive_out[g*3 +: 3] = {seg8_ff[g][lgc_pkg::BIT_SIGN],
			seg7_ff[g][lgc_pkg::BIT_SIGN], seg6_ff[g][lgc_pkg::BIT_SIGN]};
	end

	assign rdata_out = rdata_ff;
	assign irq_out   = irq_ff;
	assign gctrl_out = cfg;
endmodule
`default_nettype wire
